// *** verilog/sldrv_pkg.sv ***
// package: widths and reset values for the serial-in latched driver
package sldrv_pkg;
  localparam int unsigned STAGES = 10;
  localparam logic [9:0] SHIFT_RESET = 10'h000;
  localparam logic [9:0] LATCH_RESET = 10'h000;
  localparam logic [9:0] OUT_BLANKED = 10'h000;
  localparam int unsigned FIRST_STAGE = 0;
  localparam int unsigned LAST_STAGE = 9;
endpackage

// *** verilog/sldrv_stage.sv ***
// one shift stage with its transparent latch
`timescale 1ns/10ps
module sldrv_stage (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_en,
  input wire logic strobe,
  input wire logic shift_in,
  output logic shift_q,
  output logic latch_q
);
  logic shift_d;

  // latch sees the stage value including a shift in this same cycle
  assign shift_d = shift_en ? shift_in : shift_q; // [R03]

  // shift bit advances only on a qualified rising shift clock
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_q <= 1'h0;
    end else if (shift_en) begin
      shift_q <= shift_in; // [R02] [R03]
    end
  end

  // latch follows the stage while strobe is high, holds otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_q <= 1'h0;
    end else if (strobe) begin
      latch_q <= shift_d; // [R05] [R06]
    end
  end
endmodule

// *** verilog/sldrv_top.sv ***
// serial-in latched driver: 10-stage shift register, latches, blanked outputs
// Notes on behaviour
// R01: ten shift stages, ten latches, ten outputs
// R02: rising shift clock loads serial input
// R03: each rising edge moves bits one stage
// R04: last stage drives serial out; holds otherwise
// R05: strobe high passes stages into latches
// R06: latches follow while strobe high, else hold
// R07: host blanks outputs if strobe kept high
// R08: blanking high forces all outputs low
// R09: blanking never alters latches or shift
// R10: blanking low: outputs equal latch values
// R11: host shifts ten bits then strobes
`timescale 1ns/10ps
module sldrv_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic serial_in,
  input wire logic strobe,
  input wire logic blanking,
  output logic serial_out,
  output logic [9:0] drive_out
);
  logic shift_clk_q;
  logic shift_en;
  logic [9:0] shift_q;
  logic [9:0] latch_q;
  logic [9:0] chain_in;
  logic [3:0] fill_cnt_q;
  localparam logic [3:0] CHAIN_FULL = 4'(sldrv_pkg::STAGES); // every stage filled once

  // previous shift clock level for edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_clk_q <= 1'h0;
    end else begin
      shift_clk_q <= shift_clk;
    end
  end

  // one enable per low-to-high shift clock transition
  assign shift_en = shift_clk & ~shift_clk_q; // [R02] [R04]

  // stage 0 takes serial input, others the previous stage
  assign chain_in = {shift_q[8:0], serial_in}; // [R02] [R03]

  // ten identical stage and latch pairs
  genvar g;
  generate
    for (g = 0; g < sldrv_pkg::STAGES; g++) begin : g_stage
      sldrv_stage u_stage ( // [R01]
        .clk(clk),
        .rst(rst),
        .shift_en(shift_en),
        .strobe(strobe),
        .shift_in(chain_in[g]),
        .shift_q(shift_q[g]),
        .latch_q(latch_q[g])
      );
    end
  endgenerate

  // cascade output from last stage
  assign serial_out = shift_q[sldrv_pkg::LAST_STAGE]; // [R04]

  // output stage registered: blank forces all outputs low
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_out <= sldrv_pkg::OUT_BLANKED;
    end else if (blanking) begin // [R09] blanking gates only this register
      drive_out <= sldrv_pkg::OUT_BLANKED; // [R08]
    end else begin
      drive_out <= latch_q; // [R10]
    end
  end

  // shift edges since reset, saturating once the chain is full
  always_ff @(posedge clk) begin
    if (rst) begin
      fill_cnt_q <= 4'h0;
    end else if (shift_en && fill_cnt_q != CHAIN_FULL) begin
      fill_cnt_q <= fill_cnt_q + 4'h1;
    end
  end

  // checks: shift path, latches, output stage
  // first stage takes the serial input on a shift edge
  a_shift_load: assert property ( // [R02]
    @(posedge clk) disable iff (rst)
    $rose(shift_clk) |=> shift_q[0] == $past(serial_in))
    else $error("first stage missed serial input");

  // every stage after the first takes its neighbour on a shift edge
  a_shift_move: assert property ( // [R03]
    @(posedge clk) disable iff (rst)
    $rose(shift_clk) |=> shift_q[9:1] == $past(shift_q[8:0]))
    else $error("stages did not advance");

  // no rising shift clock, no movement, even with the clock held high
  a_shift_hold: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
    !$rose(shift_clk) |=> $stable(shift_q))
    else $error("shift register moved without a clock edge");

  // cascade output is the last stage
  a_serial_tap: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
    serial_out == shift_q[9])
    else $error("serial out not last stage");

  // strobe high copies the stages into the latches
  a_latch_pass: assert property ( // [R05]
    @(posedge clk) disable iff (rst)
    strobe && !$rose(shift_clk) |=> latch_q == $past(shift_q))
    else $error("latches not transparent");

  // strobe low keeps the latches
  a_latch_hold: assert property ( // [R06] [R09]
    @(posedge clk) disable iff (rst)
    !strobe |=> $stable(latch_q))
    else $error("latches changed with strobe low");

  // blanking forces every output low
  a_blank_low: assert property ( // [R08]
    @(posedge clk) disable iff (rst)
    blanking |=> drive_out == sldrv_pkg::OUT_BLANKED)
    else $error("outputs not blanked");

  // unblanked outputs show the latches
  a_out_follow: assert property ( // [R10]
    @(posedge clk) disable iff (rst)
    !blanking |=> drive_out == $past(latch_q))
    else $error("outputs differ from latches");

  // clock low leaves the stages alone
  a_shift_still: assert property ( // [R04] [R09]
    @(posedge clk) disable iff (rst)
    !shift_clk |=> $stable(shift_q))
    else $error("shift changed while clock low");

  // latches under strobe take the bit shifted in that same edge
  a_latch_shift: assert property ( // [R05]
    @(posedge clk) disable iff (rst)
    strobe && $rose(shift_clk) |=> latch_q == {$past(shift_q[8:0]), $past(serial_in)})
    else $error("latches missed the bit shifted under strobe");

  // reset clears stages, latches and outputs
  a_reset_clear: assert property ( // [R01]
    @(posedge clk)
    rst |=> shift_q == sldrv_pkg::SHIFT_RESET && latch_q == sldrv_pkg::LATCH_RESET
      && drive_out == sldrv_pkg::OUT_BLANKED)
    else $error("reset did not clear the driver");

  // one enable pulse per shift clock transition
  a_edge_single: assert property ( // [R02]
    @(posedge clk) disable iff (rst)
    shift_en |=> !shift_en)
    else $error("shift enable longer than one cycle");

  // cascade output takes the second to last stage on a shift edge
  a_serial_next: assert property ( // [R03]
    @(posedge clk) disable iff (rst)
    $rose(shift_clk) |=> serial_out == $past(shift_q[8]))
    else $error("cascade output did not advance");

  // cascade output steady between shift edges
  a_serial_hold: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
    !$rose(shift_clk) |=> $stable(serial_out))
    else $error("cascade output moved without a shift edge");

  // shifting goes on while the outputs are blanked
  a_blank_shift: assert property ( // [R09]
    @(posedge clk) disable iff (rst)
    blanking && $rose(shift_clk) |=> shift_q[0] == $past(serial_in))
    else $error("blanking stopped the shift register");

  // latches stay transparent while the outputs are blanked
  a_blank_latch: assert property ( // [R09]
    @(posedge clk) disable iff (rst)
    blanking && strobe && !$rose(shift_clk) |=> latch_q == $past(shift_q))
    else $error("blanking disturbed the latches");

  // held latches and no blanking keep the outputs steady
  a_out_steady: assert property ( // [R06] [R10]
    @(posedge clk) disable iff (rst)
    (!blanking && !strobe) ##1 !blanking |=> $stable(drive_out))
    else $error("outputs moved with latches held");

  // reset zeros reach the cascade output until the chain has filled
  a_fill_zero: assert property ( // [R03]
    @(posedge clk) disable iff (rst)
    fill_cnt_q < CHAIN_FULL |-> serial_out == 1'h0)
    else $error("bit reached cascade output too early");

  // outputs show the latches again right after blanking ends
  a_unblank_show: assert property ( // [R10]
    @(posedge clk) disable iff (rst)
    $fell(blanking) |=> drive_out == $past(latch_q))
    else $error("outputs did not return after blanking");

  // first cycle of a strobe pulse already loads the latches
  a_strobe_rise: assert property ( // [R05]
    @(posedge clk) disable iff (rst)
    $rose(strobe) && !$rose(shift_clk) |=> latch_q == $past(shift_q))
    else $error("short strobe pulse missed");

  // outputs stay low for as long as blanking stays high
  a_blank_hold: assert property ( // [R08]
    @(posedge clk) disable iff (rst)
    blanking ##1 blanking |=> $stable(drive_out))
    else $error("outputs moved while blanked");

  // shifting with strobe low leaves the latches untouched
  a_latch_still: assert property ( // [R06]
    @(posedge clk) disable iff (rst)
    !strobe && $rose(shift_clk) |=> $stable(latch_q))
    else $error("latches followed a shift with strobe low");

  // blanking does not move the cascade output
  a_serial_blank: assert property ( // [R09]
    @(posedge clk) disable iff (rst)
    blanking && !$rose(shift_clk) |=> $stable(serial_out))
    else $error("blanking disturbed the cascade output");
endmodule

// *** sim/sldrv_host.sv ***
// host model: serial data, shift clock, strobe and blanking
`timescale 1ns/10ps
module sldrv_host (
  input wire logic clk,
  output logic shift_clk,
  output logic serial_in,
  output logic strobe,
  output logic blanking
);
  // idle levels from time zero
  initial begin
    shift_clk = 1'h0;
    serial_in = 1'h0;
    strobe = 1'h0;
    blanking = 1'h0;
  end
  // ten bits, farthest output first, then optional strobe pulse
  task automatic send(input logic [9:0] w, input logic st);
    for (int i = 9; i >= 0; i--) begin
      serial_in = w[i];
      repeat (2) @(posedge clk);
      #1 shift_clk = 1'h1;
      repeat (2) @(posedge clk);
      #1 shift_clk = 1'h0;
    end
    strobe = st;
    repeat (4) @(posedge clk);
    #1 strobe = 1'h0;
    serial_in = ~serial_in; // released data line changes
  endtask
endmodule

// *** sim/sldrv_top_tb.sv ***
// testbench: shifts, latches and blanks the driver
`timescale 1ns/10ps
module sldrv_top_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic shift_clk, serial_in, strobe, blanking, serial_out;
  logic [9:0] drive_out;
  int failures = 0;
  int n_tests = 0;
  // 8 ns clock
  always #4 clk = ~clk;
  sldrv_host u_host (.clk(clk), .shift_clk(shift_clk), .serial_in(serial_in),
    .strobe(strobe), .blanking(blanking));
  sldrv_top u_dut (.clk(clk), .rst(rst), .shift_clk(shift_clk), .serial_in(serial_in),
    .strobe(strobe), .blanking(blanking), .serial_out(serial_out), .drive_out(drive_out));
  // compare and count
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // wait four edges, then step off the edge
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // load a word and strobe it to the outputs
  task automatic load_show();
    u_host.send(10'h2A5, 1'h1);
    settle();
    check("drive_out", drive_out, 10'h2A5);
  endtask
  // blank, then unblank with latches intact
  task automatic blank_out();
    u_host.blanking = 1'h1;
    settle();
    check("drive_out", drive_out, 10'h000);
    u_host.blanking = 1'h0;
    settle();
    check("drive_out", drive_out, 10'h2A5);
  endtask
  // shift without strobe, then strobe alone
  task automatic hold_latch();
    u_host.send(10'h35A, 1'h0);
    settle();
    check("drive_out", drive_out, 10'h2A5);
    check("serial_out", {9'h000, serial_out}, 10'h001);
    u_host.strobe = 1'h1;
    settle();
    u_host.strobe = 1'h0;
    settle();
    check("drive_out", drive_out, 10'h35A);
  endtask
  // reset in mid run clears outputs and cascade output
  task automatic reset_mid();
    rst = 1'h1;
    repeat (2) @(posedge clk);
    #1;
    check("drive_out", drive_out, 10'h000);
    check("serial_out", {9'h000, serial_out}, 10'h000);
    rst = 1'h0;
    settle();
    check("drive_out", drive_out, 10'h000);
  endtask
  // strobe held high during entry, outputs blanked throughout
  task automatic bypass_latch();
    u_host.blanking = 1'h1;
    u_host.strobe = 1'h1;
    fork
      u_host.send(10'h1C3, 1'h1);
      repeat (40) begin
        @(posedge clk);
        #1;
        check("drive_out", drive_out, 10'h000);
      end
    join
    u_host.blanking = 1'h0;
    settle();
    check("drive_out", drive_out, 10'h1C3);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'h0;
    load_show();
    blank_out();
    hold_latch();
    reset_mid();
    bypass_latch();
    complete_run();
  end
  // watchdog
  initial begin
    #20000;
    failures++;
    complete_run();
  end
endmodule
